// File: logic/ctc_regs.sv
// Added by the designer: register access over APB.
`timescale 1ns/10ps
`include "ctc_consts.svh"
// Operation
// - Two-bit selector picks channel input source
// - Upper offset register holds offset bits 23:8
// - Lower offset upper byte; low byte zero
// - Upper gain register holds unsigned bits 23:8
// - Lower gain upper byte; low byte zero
// - Upper gain register resets to 8000h
// - Configuration register resets to 0000h
// - Upper offset register resets to 0000h
// - Lower offset register resets to 0000h
// - Lower gain register resets to 0000h
module ctc_regs
    import ctc_pkg::*;
#(
    parameter int AW = 8 // APB address width
) (
    input  wire logic          mclk,
    input  wire logic          nrst,
    input  wire logic          ce,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [AW-1:0] paddr,
    input  wire logic [31:0]   pwdata,
    input  wire logic [3:0]    pstrb,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    output ctc_src_t           chan2_source_select,
    output logic               chan2_pair_on,
    output logic               chan2_inputs_shorted,
    output logic               chan2_test_pos,
    output logic               chan2_test_neg,
    output ctc_trim_t          chan2_offset_trim,
    output ctc_trim_t          chan2_gain_trim
);

    // Address must at least cover the highest byte address
    if (AW < 8) begin : g_bad_aw
        $error("ctc_regs: AW must be at least 8");
    end

    // Reset values and masks per slot
    localparam ctc_word_t RST_V [`CTC_NUM_SLOTS] = '{
        `CTC_RST_CFG, `CTC_RST_OCH, `CTC_RST_OCL,
        `CTC_RST_GNH, `CTC_RST_GNL};
    localparam ctc_word_t MSK_V [`CTC_NUM_SLOTS] = '{
        `CTC_MSK_CFG, `CTC_MSK_HI, `CTC_MSK_LO,
        `CTC_MSK_HI, `CTC_MSK_LO};

    // Index compare; unaligned addresses never match
    function automatic logic idx_hit(
        input logic [AW-1:0] a,
        input logic [5:0]    idx
    );
        logic [AW-3:0] want;
        want = (AW-2)'(idx);
        return (a[1:0] == 2'b00) && (a[AW-1:2] == want);
    endfunction : idx_hit

    // Address to slot, used by read and write paths
    function automatic logic [2:0] ctc_slot(
        input logic [AW-1:0] a
    );
        logic [2:0] s;
        s = `CTC_SLOT_NONE;
        if (idx_hit(a, `CTC_IDX_CFG)) begin
            s = `CTC_SLOT_CFG;
        end else if (idx_hit(a, `CTC_IDX_OCH)) begin
            s = `CTC_SLOT_OCH;
        end else if (idx_hit(a, `CTC_IDX_OCL)) begin
            s = `CTC_SLOT_OCL;
        end else if (idx_hit(a, `CTC_IDX_GNH)) begin
            s = `CTC_SLOT_GNH;
        end else if (idx_hit(a, `CTC_IDX_GNL)) begin
            s = `CTC_SLOT_GNL;
        end
        return s;
    endfunction : ctc_slot

    ctc_word_t  reg_q [`CTC_NUM_SLOTS]; // Register contents
    logic [2:0] slot;                   // Decoded slot now
    logic       setup;                  // Request not yet answered
    logic       access;                 // Completing access phase
    logic       wr_go;                  // Write takes effect
    ctc_word_t  rd_word;                // Read mux output

    // Phase decode; pready rises one enabled cycle after a request is seen
    always_comb begin
        slot   = ctc_slot(paddr);
        setup  = psel && !pready;
        access = psel && penable && pready;
        wr_go  = access && pwrite && !pslverr;
    end

    // Register slots; read-only bits held by mask
    generate
        for (genvar i = 0; i < `CTC_NUM_SLOTS; i++) begin : g_reg
            ctc_field_reg #(
                .RST_VAL (RST_V[i]),
                .WR_MASK (MSK_V[i])
            ) u_reg (
                .mclk    (mclk),
                .nrst    (nrst),
                .ce      (ce),
                .wr_en   (wr_go && (slot == 3'(i))),
                .lane_en (pstrb[1:0]),
                .wdata   (pwdata[15:0]),
                .q       (reg_q[i])
            );
        end
    endgenerate

    // Read mux; unmapped slots return zero
    always_comb begin
        rd_word = 16'h0000;
        if (slot < 3'(`CTC_NUM_SLOTS)) begin
            rd_word = reg_q[slot];
        end
    end

    // Answer one cycle after a request is seen, so access completes
    // at once; a request met by low ce simply waits. ce must not
    // fall in an access cycle: pready, a flop, cannot be taken back.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pready <= 1'b0;
        end else if (ce) begin
            pready <= setup;
        end
    end

    // Error flag for unmapped or unaligned addresses
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pslverr <= 1'b0;
        end else if (ce) begin
            pslverr <= setup && (slot == `CTC_SLOT_NONE);
        end
    end

    // Read data latched in setup; upper half always zero
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h0000_0000;
        end else if (ce) begin
            if (setup && !pwrite) begin
                prdata <= {16'h0000, rd_word};
            end else if (!psel) begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // Source selector copied from the config register
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            chan2_source_select <= CTC_SRC_PAIR;
        end else if (ce) begin
            chan2_source_select <= ctc_src_t'(
                reg_q[`CTC_SLOT_CFG][`CTC_SEL_MSB:`CTC_SEL_LSB]);
        end
    end

    // One-hot input path controls for the analog front
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            chan2_pair_on        <= 1'b1;
            chan2_inputs_shorted <= 1'b0;
            chan2_test_pos       <= 1'b0;
            chan2_test_neg       <= 1'b0;
        end else if (ce) begin
            chan2_pair_on        <= 1'b0;
            chan2_inputs_shorted <= 1'b0;
            chan2_test_pos       <= 1'b0;
            chan2_test_neg       <= 1'b0;
            case (ctc_src_t'(reg_q[`CTC_SLOT_CFG][1:0]))
                CTC_SRC_PAIR:  chan2_pair_on        <= 1'b1;
                CTC_SRC_SHORT: chan2_inputs_shorted <= 1'b1;
                CTC_SRC_TPOS:  chan2_test_pos       <= 1'b1;
                CTC_SRC_TNEG:  chan2_test_neg       <= 1'b1;
                default:       chan2_pair_on        <= 1'b1;
            endcase
        end
    end

    // Signed offset word joined from its two halves.
    // Halves are written separately, so a torn value can
    // show for one write gap; the data path must tolerate it.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            chan2_offset_trim <= {RST_V[`CTC_SLOT_OCH],
                RST_V[`CTC_SLOT_OCL][`CTC_LO_FLD_MSB:`CTC_LO_FLD_LSB]};
        end else if (ce) begin
            chan2_offset_trim <= {reg_q[`CTC_SLOT_OCH],
                reg_q[`CTC_SLOT_OCL][`CTC_LO_FLD_MSB:`CTC_LO_FLD_LSB]};
        end
    end

    // Unsigned gain word; 800000h is unity
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            chan2_gain_trim <= {RST_V[`CTC_SLOT_GNH],
                RST_V[`CTC_SLOT_GNL][`CTC_LO_FLD_MSB:`CTC_LO_FLD_LSB]};
        end else if (ce) begin
            chan2_gain_trim <= {reg_q[`CTC_SLOT_GNH],
                reg_q[`CTC_SLOT_GNL][`CTC_LO_FLD_MSB:`CTC_LO_FLD_LSB]};
        end
    end

    // Checks

    logic [`CTC_NUM_SLOTS-1:0] wr_seen_q; // Slot written since reset

    // Tracks which slots have seen a write
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wr_seen_q <= '0;
        end else if (ce) begin
            for (int k = 0; k < `CTC_NUM_SLOTS; k++) begin
                if (wr_go && slot == 3'(k)) begin
                    wr_seen_q[k] <= 1'b1;
                end
            end
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    // Setup phase of a transfer
    sequence s_setup;
        ce && psel && !penable;
    endsequence

    // Full write to the upper offset register
    sequence s_wr_och;
        ce && wr_go && slot == `CTC_SLOT_OCH && pstrb[1:0] == 2'b11;
    endsequence

    // Full write to the upper gain register
    sequence s_wr_gnh;
        ce && wr_go && slot == `CTC_SLOT_GNH && pstrb[1:0] == 2'b11;
    endsequence

    // Upper-byte write to the lower offset register
    sequence s_wr_ocl;
        ce && wr_go && slot == `CTC_SLOT_OCL && pstrb[1];
    endsequence

    // Upper-byte write to the lower gain register
    sequence s_wr_gnl;
        ce && wr_go && slot == `CTC_SLOT_GNL && pstrb[1];
    endsequence

    AST_SETUP_READY: assert property (
        s_setup |=> pready)
        else $error("pready not high after setup");

    AST_UNMAPPED_ERR: assert property (
        s_setup ##0 (slot == `CTC_SLOT_NONE) |=> pslverr && pready)
        else $error("unmapped address not flagged");

    AST_SRC_DECODE: assert property (
        ce ##1 1'b1 |-> chan2_source_select ==
            ctc_src_t'($past(reg_q[`CTC_SLOT_CFG][1:0]))
            && chan2_test_pos == (chan2_source_select == CTC_SRC_TPOS)
            && chan2_test_neg == (chan2_source_select == CTC_SRC_TNEG))
        else $error("source decode mismatch");

    AST_OFFSET_HIGH: assert property (
        s_wr_och ##1 ce |=>
            chan2_offset_trim[23:8] == $past(pwdata[15:0], 2))
        else $error("offset upper bits not taken");

    AST_OFFSET_LOW_ZERO: assert property (
        reg_q[`CTC_SLOT_OCL][7:0] == 8'h00)
        else $error("offset low byte not zero");

    AST_GAIN_HIGH: assert property (
        s_wr_gnh ##1 ce |=>
            chan2_gain_trim[23:8] == $past(pwdata[15:0], 2))
        else $error("gain upper bits not taken");

    AST_GAIN_LOW_ZERO: assert property (
        reg_q[`CTC_SLOT_GNL][7:0] == 8'h00)
        else $error("gain low byte not zero");

    AST_GAIN_RESET: assert property (
        !wr_seen_q[`CTC_SLOT_GNH] |-> reg_q[`CTC_SLOT_GNH] == 16'h8000)
        else $error("gain upper reset value lost");

    AST_CFG_RESET: assert property (
        !wr_seen_q[`CTC_SLOT_CFG] |-> reg_q[`CTC_SLOT_CFG] == 16'h0000)
        else $error("config reset value lost");

    AST_OCH_RESET: assert property (
        !wr_seen_q[`CTC_SLOT_OCH] |-> reg_q[`CTC_SLOT_OCH] == 16'h0000)
        else $error("offset upper reset value lost");

    AST_OCL_RESET: assert property (
        !wr_seen_q[`CTC_SLOT_OCL] |-> reg_q[`CTC_SLOT_OCL] == 16'h0000)
        else $error("offset lower reset value lost");

    AST_GNL_RESET: assert property (
        !wr_seen_q[`CTC_SLOT_GNL] |-> reg_q[`CTC_SLOT_GNL] == 16'h0000)
        else $error("gain lower reset value lost");

    AST_CFG_RO_ZERO: assert property (
        s_setup ##0 ((slot == `CTC_SLOT_CFG) && !pwrite) |=>
            prdata[5:3] == 3'b000)
        else $error("config bits 5:3 read nonzero");

    // Lower offset byte reaches the joined word
    AST_OFFSET_LOW: assert property (
        s_wr_ocl ##1 ce |=>
            chan2_offset_trim[7:0] == $past(pwdata[15:8], 2))
        else $error("offset lower bits not taken");

    // Lower gain byte reaches the joined word
    AST_GAIN_LOW: assert property (
        s_wr_gnl ##1 ce |=>
            chan2_gain_trim[7:0] == $past(pwdata[15:8], 2))
        else $error("gain lower bits not taken");

    // Ready stands for a single enabled cycle
    AST_READY_ONE: assert property (
        ce && pready |=> !pready)
        else $error("pready held past one cycle");

    // Low clock enable holds pready, prdata, the selector and both trim words
    AST_CE_FREEZE: assert property (
        !ce |=> $stable(pready) && $stable(prdata)
            && $stable(chan2_source_select)
            && $stable(chan2_offset_trim) && $stable(chan2_gain_trim))
        else $error("state moved while clock enable low");

    // Pair and short controls agree with the selector
    AST_PATH_DECODE: assert property (
        chan2_pair_on == (chan2_source_select == CTC_SRC_PAIR)
            && chan2_inputs_shorted ==
               (chan2_source_select == CTC_SRC_SHORT))
        else $error("input path decode mismatch");

endmodule : ctc_regs

// File: logic/ctc_consts.svh
`ifndef CTC_CONSTS_SVH
`define CTC_CONSTS_SVH

// Register indices; byte address is four times the index
`define CTC_IDX_CFG 6'h13
`define CTC_IDX_OCH 6'h14
`define CTC_IDX_OCL 6'h15
`define CTC_IDX_GNH 6'h16
`define CTC_IDX_GNL 6'h17

// Slot numbers inside the bank
`define CTC_SLOT_CFG 3'h0
`define CTC_SLOT_OCH 3'h1
`define CTC_SLOT_OCL 3'h2
`define CTC_SLOT_GNH 3'h3
`define CTC_SLOT_GNL 3'h4
`define CTC_SLOT_NONE 3'h7
`define CTC_NUM_SLOTS 5

// Reset values
`define CTC_RST_CFG 16'h0000
`define CTC_RST_OCH 16'h0000
`define CTC_RST_OCL 16'h0000
`define CTC_RST_GNH 16'h8000
`define CTC_RST_GNL 16'h0000

// Writable-bit masks; zero bits are read-only zero
`define CTC_MSK_CFG 16'hffc7
`define CTC_MSK_HI 16'hffff
`define CTC_MSK_LO 16'hff00

// Field positions
`define CTC_SEL_LSB 0
`define CTC_SEL_MSB 1
`define CTC_CFG_RO_LSB 3
`define CTC_CFG_RO_MSB 5
`define CTC_LO_FLD_LSB 8
`define CTC_LO_FLD_MSB 15

`endif

// File: logic/ctc_pkg.sv
package ctc_pkg;

    // Source selection of the channel input
    typedef enum logic [1:0] {
        CTC_SRC_PAIR,
        CTC_SRC_SHORT,
        CTC_SRC_TPOS,
        CTC_SRC_TNEG
    } ctc_src_t;

    // Register word and calibration word
    typedef logic [15:0] ctc_word_t;
    typedef logic [23:0] ctc_trim_t;

endpackage : ctc_pkg

// File: logic/ctc_field_reg.sv
`timescale 1ns/10ps
// One 16-bit register with per-bit write mask and byte lanes
module ctc_field_reg
    import ctc_pkg::*;
#(
    parameter ctc_word_t RST_VAL = 16'h0000,
    parameter ctc_word_t WR_MASK = 16'hffff
) (
    input  wire logic      mclk,
    input  wire logic      nrst,
    input  wire logic      ce,
    input  wire logic      wr_en,
    input  wire logic [1:0] lane_en,
    input  wire ctc_word_t wdata,
    output ctc_word_t      q
);

    ctc_word_t be_mask; // Byte lanes widened to bits

    // Lanes widen to full bit masks
    always_comb begin
        be_mask = {{8{lane_en[1]}}, {8{lane_en[0]}}};
    end

    // Read-only bits never change from their reset value
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            q <= RST_VAL;
        end else if (ce && wr_en) begin
            q <= (q & ~(WR_MASK & be_mask))
               | (wdata & WR_MASK & be_mask);
        end
    end

endmodule : ctc_field_reg

// File: verif/test_channel_two_cfg_cal_regs.sv
`timescale 1ns/10ps
module test_channel_two_cfg_cal_regs;
    import ctc_pkg::*;

    // Bus side, driven by the bench
    logic        mclk;
    logic        nrst;
    logic        ce;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    // Answers and channel outputs
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    ctc_src_t    sel;
    logic        pair_on;
    logic        shorted;
    logic        tpos;
    logic        tneg;
    ctc_trim_t   off_trim;
    ctc_trim_t   gain_trim;
    // Bookkeeping
    int          failures    = 0;
    int          checks_done = 0;
    int          cycles      = 0;
    logic [31:0] rd;
    logic        err;

    // Byte addresses are four times the register index
    localparam logic [7:0]  ADR [5] = '{8'h4c, 8'h50, 8'h54, 8'h58, 8'h5c};
    localparam logic [15:0] RST [5] = '{16'h0000, 16'h0000, 16'h0000,
                                        16'h8000, 16'h0000};

    ctc_regs #(.AW(8)) DUT (
        .mclk                 (mclk),
        .nrst                 (nrst),
        .ce                   (ce),
        .psel                 (psel),
        .penable              (penable),
        .pwrite               (pwrite),
        .paddr                (paddr),
        .pwdata               (pwdata),
        .pstrb                (pstrb),
        .prdata               (prdata),
        .pready               (pready),
        .pslverr              (pslverr),
        .chan2_source_select  (sel),
        .chan2_pair_on        (pair_on),
        .chan2_inputs_shorted (shorted),
        .chan2_test_pos       (tpos),
        .chan2_test_neg       (tneg),
        .chan2_offset_trim    (off_trim),
        .chan2_gain_trim      (gain_trim)
    );

    // Free-running 25 MHz clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // Hang guard; the whole run needs about a hundred cycles
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            failures++;
            final_report();
        end
    end

    // Verdict and end of run
    task final_report();
        if (failures == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report

    // Single comparison point
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // One APB transfer; waits on pready, never on a fixed count
    task apb(input logic wr, input logic [7:0] a, input logic [15:0] d,
             input logic [3:0] s, output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {16'h0000, d};
        pstrb   <= s;
        @(posedge mclk);
        penable <= 1'b1;
        // Request held until pready is seen high at an edge
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            chk(32'h0000_0000, 32'h0000_0001);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Values straight after reset, then every register read back
    task t_reset();
        #1;
        chk(sel, 32'h0);
        chk({tneg, tpos, shorted, pair_on}, 32'h1);
        chk(off_trim, 32'h0);
        chk(gain_trim, 32'h0080_0000);
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, ADR[i], 16'h0000, 4'h0, rd, err);
            chk(rd, {16'h0000, RST[i]});
        end
    endtask : t_reset

    // Every source code; reserved bits written zero, read-only 5:3 one
    task t_cfg();
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 8'h4c, 16'h0038 | 16'(i), 4'hf, rd, err);
            @(posedge mclk);
            #1;
            chk(sel, 32'(i));
            chk({tneg, tpos, shorted, pair_on}, 32'h1 << i);
            apb(1'b0, 8'h4c, 16'h0000, 4'h0, rd, err);
            chk(rd, 32'(i));
        end
        // Back to the documented zero pattern
        apb(1'b1, 8'h4c, 16'h0000, 4'hf, rd, err);
    endtask : t_cfg

    // Split 24-bit word: both halves, read-only byte, lane strobes
    task t_trim(input logic [7:0] ah, input logic [7:0] al,
                input logic [15:0] hi, input logic [7:0] lo,
                input logic is_gain);
        apb(1'b1, ah, hi, 4'hf, rd, err);
        apb(1'b1, al, {lo, 8'hff}, 4'hf, rd, err);
        @(posedge mclk);
        #1;
        chk(is_gain ? gain_trim : off_trim, {8'h00, hi, lo});
        apb(1'b0, ah, 16'h0000, 4'h0, rd, err);
        chk(rd, {16'h0000, hi});
        apb(1'b0, al, 16'h0000, 4'h0, rd, err);
        chk(rd, {16'h0000, lo, 8'h00});
        // Strobe on the read-only lane alone must change nothing
        apb(1'b1, al, 16'h0000, 4'h1, rd, err);
        apb(1'b0, al, 16'h0000, 4'h0, rd, err);
        chk(rd, {16'h0000, lo, 8'h00});
    endtask : t_trim

    // Unmapped and unaligned accesses are refused and leave no trace
    task t_err();
        apb(1'b1, 8'h60, 16'h1234, 4'hf, rd, err);
        chk(err, 32'h1);
        apb(1'b1, 8'h4d, 16'h0003, 4'hf, rd, err);
        chk(err, 32'h1);
        apb(1'b0, 8'h60, 16'h0000, 4'h0, rd, err);
        chk(err, 32'h1);
        chk(rd, 32'h0);
        apb(1'b0, 8'h4c, 16'h0000, 4'h0, rd, err);
        chk(err, 32'h0);
        chk(rd, 32'h0);
    endtask : t_err

    // Low clock enable stalls a request and freezes the outputs
    task t_ce();
        ce <= 1'b0;
        fork
            apb(1'b1, 8'h58, 16'h1234, 4'hf, rd, err);
            begin
                repeat (3) @(posedge mclk);
                chk(pready, 32'h0);
                chk(gain_trim, 32'h00ff_ffff);
                ce <= 1'b1;
            end
        join
        @(posedge mclk);
        #1;
        chk(gain_trim, 32'h0012_34ff);
    endtask : t_ce

    // Main sequence
    initial begin
        ce      = 1'b1;
        nrst    = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        pstrb   = 4'h0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        t_reset();
        t_cfg();
        // Negative offset, then full-scale gain
        t_trim(8'h50, 8'h54, 16'h8001, 8'hfe, 1'b0);
        t_trim(8'h58, 8'h5c, 16'hffff, 8'hff, 1'b1);
        t_err();
        t_ce();
        final_report();
    end

endmodule : test_channel_two_cfg_cal_regs
